// ==== toc_pkg.sv ====
// constants, types and helper functions of the timer output compare unit
//
// Contract
// - compare value is double buffered in both pwm waveform modes
// - normal and clear-on-match modes write the active compare value at once
// - buffered value moves to active value only at top or bottom
// - cpu reads and writes the buffer when buffered, else the active value
// - force strobe in non-pwm modes produces a forced comparator match
// - forced match sets no flag and never clears or reloads the counter
// - forced match sets, clears or toggles the output like a real match
// - counter write blocks any compare match in the next timer tick
// - compare output state keeps its value across waveform mode changes
// - compare output mode is not buffered and acts immediately
// - compare output mode decides the state after the next match
// - compare output mode selects pin source, overriding port data but not port direction
// - reset clears the internal compare output state to zero
// - counter equal to active compare value sets flag on next tick
// - flag clears on interrupt execution or software writing one
// - mode 0 is normal, mode 2 is clear-on-match, both non-pwm
// - non-pwm compare output mode 1 toggles the output on each match
package toc_pkg;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PC_PWM = 2'h1;
  localparam logic [1:0] WGM_CLEAR_ON_MATCH = 2'h2;
  localparam logic [1:0] WGM_FAST_PWM = 2'h3;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic OC_RESET = 1'b0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic BLOCK_RESET = 1'b0;
  localparam logic [7:0] CMP_RESET = 8'h00;

  typedef enum logic [1:0] {TOC_ACT_NONE, TOC_ACT_TOGGLE, TOC_ACT_CLEAR, TOC_ACT_SET} toc_act_e;

  // mode bits from the control register
  typedef struct packed {
    logic [1:0] waveform_gen_mode;
    logic [1:0] compare_output_mode;
  } toc_cfg_s;

  // counter status, all on the timer's own clock
  typedef struct packed {
    logic tick;
    logic at_top;
    logic at_bottom;
    logic [7:0] count_value;
  } toc_cnt_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic toc_is_pwm(input logic [1:0] wgm);
    toc_is_pwm = (wgm == WGM_PC_PWM) || (wgm == WGM_FAST_PWM);
  endfunction : toc_is_pwm

  // action of a match for a given mode pair; bottom gives the opposite in pwm
  function automatic toc_act_e toc_match_act(input logic [1:0] wgm, input logic [1:0] com);
    toc_match_act = TOC_ACT_NONE;
    unique case (com)
      COM_OFF: toc_match_act = TOC_ACT_NONE;
      COM_TOGGLE: toc_match_act = toc_is_pwm(wgm) ? TOC_ACT_NONE : TOC_ACT_TOGGLE;
      COM_CLEAR: toc_match_act = TOC_ACT_CLEAR;
      COM_SET: toc_match_act = TOC_ACT_SET;
    endcase
  endfunction : toc_match_act

endpackage : toc_pkg

// ==== toc_cmp_buf.sv ====
// compare value store: cpu buffer and active compare register
`timescale 1ns/10ps
module toc_cmp_buf #(
  parameter int WIDTH = 8
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic buffered_in,
  input wire logic update_in,
  input wire logic wr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  output logic [WIDTH-1:0] active_out,
  output logic [WIDTH-1:0] rdata_out
);

  logic [WIDTH-1:0] buf_reg;
  logic [WIDTH-1:0] buf_next;
  logic [WIDTH-1:0] active_reg;
  logic [WIDTH-1:0] active_next;
  logic [WIDTH-1:0] rdata_reg;
  logic [WIDTH-1:0] rdata_next;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  // a direct write also lands in the buffer so a later switch to pwm
  // does not load a stale value at the first update point
  always_comb begin
    buf_next = wr_in ? wdata_in : buf_reg;
    active_next = active_reg;
    if (!buffered_in && wr_in) begin
      active_next = wdata_in;
    end else if (buffered_in && update_in) begin
      active_next = buf_reg;
    end
    rdata_next = buffered_in ? buf_next : active_next;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      buf_reg <= WIDTH'(toc_pkg::CMP_RESET);
      active_reg <= WIDTH'(toc_pkg::CMP_RESET);
      rdata_reg <= WIDTH'(toc_pkg::CMP_RESET);
    end else begin
      buf_reg <= buf_next;
      active_reg <= active_next;
      rdata_reg <= rdata_next;
    end
  end

  assign active_out = active_reg;
  assign rdata_out = rdata_reg;

endmodule : toc_cmp_buf

// ==== toc_unit.sv ====
// output compare unit of the 8-bit timer: compare, flag, force, block, output
`timescale 1ns/10ps
module toc_unit #(
  parameter int WIDTH = 8
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input toc_pkg::toc_cfg_s cfg_in,
  input toc_pkg::toc_cnt_s cnt_in,
  input wire logic count_write_in,
  input wire logic cmp_wr_in,
  input wire logic [WIDTH-1:0] cmp_wdata_in,
  input wire logic force_compare_strobe_in,
  input wire logic flag_clear_in,
  input wire logic int_ack_in,
  input wire logic port_data_in,
  input wire logic port_dir_in,
  output logic [WIDTH-1:0] cmp_rdata_out,
  output logic [WIDTH-1:0] compare_value_out,
  output logic compare_match_flag_out,
  output logic match_out,
  output logic compare_output_out,
  output logic pin_out,
  output logic pin_oe_out
);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic pwm;
  logic update_pt;
  logic [WIDTH-1:0] active_val;
  toc_pkg::toc_act_e act;

  assign pwm = toc_pkg::toc_is_pwm(cfg_in.waveform_gen_mode);
  // fast pwm reloads at bottom, phase correct at top
  assign update_pt = cnt_in.tick &&
    ((cfg_in.waveform_gen_mode == toc_pkg::WGM_FAST_PWM) ? cnt_in.at_bottom : cnt_in.at_top);
  // mode bits read live each cycle, never latched with the compare value
  assign act = toc_pkg::toc_match_act(cfg_in.waveform_gen_mode,
    cfg_in.compare_output_mode);

  toc_cmp_buf #(
    .WIDTH(WIDTH)
  ) u_cmp_buf (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .buffered_in(pwm),
    .update_in(update_pt),
    .wr_in(cmp_wr_in),
    .wdata_in(cmp_wdata_in),
    .active_out(active_val),
    .rdata_out(cmp_rdata_out)
  );

  // ----------------------------------------------------------------
  // match and blocking
  // ----------------------------------------------------------------
  logic block_reg;
  logic block_next;
  logic match_hit;
  logic force_eff;

  // a tick that arrives while blocked is swallowed and ends the block
  always_comb begin
    block_next = block_reg;
    if (count_write_in) begin
      block_next = 1'b1;
    end else if (cnt_in.tick) begin
      block_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      block_reg <= toc_pkg::BLOCK_RESET;
    end else begin
      block_reg <= block_next;
    end
  end

  assign match_hit = cnt_in.tick && (cnt_in.count_value == active_val) &&
    !block_reg && !count_write_in;
  // strobe is used combinationally only, no register holds it
  assign force_eff = force_compare_strobe_in && !pwm;
  // counter clear request carries only real matches
  assign match_out = match_hit;

  // ----------------------------------------------------------------
  // compare match flag
  // ----------------------------------------------------------------
  logic flag_reg;
  logic flag_next;

  // set beats clear so a match in the clearing cycle is not lost
  always_comb begin
    flag_next = flag_reg;
    if (flag_clear_in || int_ack_in) begin
      flag_next = 1'b0;
    end
    if (match_hit) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      flag_reg <= toc_pkg::FLAG_RESET;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign compare_match_flag_out = flag_reg;

  // ----------------------------------------------------------------
  // compare output state and pin
  // ----------------------------------------------------------------
  logic oc_reg;
  logic oc_next;
  logic bottom_ev;

  assign bottom_ev = pwm && cnt_in.tick && cnt_in.at_bottom;

  // no term looks at the waveform mode change itself, so the state holds
  always_comb begin
    oc_next = oc_reg;
    if (match_hit || force_eff) begin
      unique case (act)
        toc_pkg::TOC_ACT_NONE: oc_next = oc_reg;
        toc_pkg::TOC_ACT_TOGGLE: oc_next = !oc_reg;
        toc_pkg::TOC_ACT_CLEAR: oc_next = 1'b0;
        toc_pkg::TOC_ACT_SET: oc_next = 1'b1;
      endcase
    end else if (bottom_ev) begin
      // pwm period restart drives the opposite level of the match action
      if (act == toc_pkg::TOC_ACT_CLEAR) begin
        oc_next = 1'b1;
      end else if (act == toc_pkg::TOC_ACT_SET) begin
        oc_next = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      oc_reg <= toc_pkg::OC_RESET;
    end else begin
      oc_reg <= oc_next;
    end
  end

  assign compare_output_out = oc_reg;
  assign compare_value_out = active_val;
  // pin stays under port direction, so set the state first before enabling
  assign pin_out = (cfg_in.compare_output_mode != toc_pkg::COM_OFF) ?
    oc_reg : port_data_in;
  assign pin_oe_out = port_dir_in;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic raw_eq;

  // comparator rebuilt apart from match_hit, so a force leaking into the clear is caught
  assign raw_eq = cnt_in.tick && (cnt_in.count_value == active_val);

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_cnt_write;
    count_write_in ##1 (cnt_in.tick && !count_write_in);
  endsequence

  sequence s_forced_only;
    force_eff && !match_hit && !flag_reg;
  endsequence

  // flag: set one clock after a match, cleared by software or the interrupt
  a_flag_on_match: assert property (match_hit |=> compare_match_flag_out)
    else $error("flag not set after match");
  a_flag_clear_ok: assert property ((flag_clear_in || int_ack_in) && !match_hit
    |=> !compare_match_flag_out)
    else $error("flag not cleared");

  // forced matches: no flag, no counter clear, same output action as a match
  a_force_no_flag: assert property (s_forced_only |=> !compare_match_flag_out)
    else $error("forced match set the flag");
  a_force_no_clear: assert property (force_eff && !raw_eq |-> !match_out)
    else $error("forced match cleared the counter");
  a_force_toggle: assert property (force_eff && !pwm &&
    cfg_in.compare_output_mode == toc_pkg::COM_TOGGLE |=> oc_reg != $past(oc_reg))
    else $error("forced toggle missing");
  a_force_set: assert property (force_eff &&
    cfg_in.compare_output_mode == toc_pkg::COM_SET |=> compare_output_out)
    else $error("forced set missing");
  a_force_clear: assert property (force_eff &&
    cfg_in.compare_output_mode == toc_pkg::COM_CLEAR |=> !compare_output_out)
    else $error("forced clear missing");
  a_pwm_no_force: assert property (pwm && force_compare_strobe_in && !match_hit &&
    !bottom_ev |=> $stable(oc_reg))
    else $error("force acted in pwm mode");

  // counter write, output state, compare value and pin
  a_write_blocks: assert property (s_cnt_write |-> !match_hit)
    else $error("match after counter write");
  a_match_toggle: assert property (match_hit && !pwm &&
    cfg_in.compare_output_mode == toc_pkg::COM_TOGGLE |=> oc_reg != $past(oc_reg))
    else $error("match toggle missing");
  a_mode_keep_oc: assert property (!match_hit && !force_eff && !bottom_ev
    |=> $stable(oc_reg))
    else $error("output changed without cause");
  // its own disable lets the reset cycles themselves be watched
  a_reset_oc: assert property (disable iff (1'b0) !rst_b_in
    |=> !compare_output_out)
    else $error("compare output not cleared by reset");
  a_direct_write: assert property (!pwm && cmp_wr_in
    |=> active_val == $past(cmp_wdata_in))
    else $error("direct write not taken");
  a_buf_hold: assert property (pwm && !update_pt && $past(pwm)
    |=> $stable(active_val))
    else $error("active value moved off update point");
  a_pin_source: assert property (cfg_in.compare_output_mode != toc_pkg::COM_OFF
    |-> pin_out == oc_reg)
    else $error("pin not driven from compare output");

endmodule : toc_unit

// ==== toc_pin_model.sv ====
// model of the port pad that the compare unit drives, with a pull-up
`timescale 1ns/10ps
module toc_pin_model (
  input wire logic pin_in,
  input wire logic oe_in,
  output logic pad_out
);
  // a released pad floats to the pull-up level, never the last driven value
  assign pad_out = oe_in ? pin_in : 1'b1;
endmodule : toc_pin_model

// ==== toc_unit_tb.sv ====
// self-checking testbench of the timer output compare unit
`timescale 1ns/10ps
module toc_unit_tb;
  logic mclk_in, rst_b_in, count_write_in, cmp_wr_in, force_in, fclr_in, ack_in;
  logic port_data_in, port_dir_in, m;
  logic [7:0] cmp_wdata_in;
  toc_pkg::toc_cfg_s cfg;
  toc_pkg::toc_cnt_s cnt;
  logic [7:0] rdata, cval;
  logic flag, match, oc, pin, oe, pad;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;

  toc_unit #(.WIDTH(8)) dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .cfg_in(cfg),
    .cnt_in(cnt), .count_write_in(count_write_in), .cmp_wr_in(cmp_wr_in),
    .cmp_wdata_in(cmp_wdata_in), .force_compare_strobe_in(force_in),
    .flag_clear_in(fclr_in), .int_ack_in(ack_in), .port_data_in(port_data_in),
    .port_dir_in(port_dir_in), .cmp_rdata_out(rdata), .compare_value_out(cval),
    .compare_match_flag_out(flag), .match_out(match), .compare_output_out(oc),
    .pin_out(pin), .pin_oe_out(oe));
  toc_pin_model pad_model (.pin_in(pin), .oe_in(oe), .pad_out(pad));

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // the run needs some 70 cycles; a stuck sequence is cut off well past that
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one timer tick; the combinational match is sampled before the edge
  // an idle cycle follows, so a second call never raises tick in the step it fell
  task automatic tick(input logic [7:0] v, input logic top, input logic bot);
    cnt = '{1'b1, top, bot, v};
    #1 m = match;
    @(negedge mclk_in);
    cnt.tick = 1'b0;
    @(negedge mclk_in);
  endtask : tick

  task automatic wr(input logic [7:0] v);
    cmp_wr_in = 1'b1;
    cmp_wdata_in = v;
    @(negedge mclk_in);
    cmp_wr_in = 1'b0;
    @(negedge mclk_in);
  endtask : wr

  // force strobe for one cycle under a given output mode
  task automatic frc(input logic [1:0] com);
    cfg.compare_output_mode = com;
    force_in = 1'b1;
    #1 m = match;
    @(negedge mclk_in);
    force_in = 1'b0;
    @(negedge mclk_in);
  endtask : frc

  task automatic results;
    $display("checks=%0d mismatches=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b_in = 1'b0;
    {count_write_in, cmp_wr_in, force_in, fclr_in, ack_in, m} = '0;
    port_data_in = 1'b1;
    port_dir_in = 1'b0;
    cmp_wdata_in = 8'h00;
    cfg = '{toc_pkg::WGM_NORMAL, toc_pkg::COM_TOGGLE};
    cnt = '{1'b0, 1'b0, 1'b0, 8'h00};
    repeat (20) @(negedge mclk_in);
    rst_b_in = 1'b1;
    check(oc, 8'h00);
    check(flag, 8'h00);
    check(pad, 8'h01);
    $display("test reset done");
    // direct write in normal mode reaches the active value at once
    wr(8'h40);
    check(cval, 8'h40);
    check(rdata, 8'h40);
    // real match: pulse now, flag and toggle after the edge
    tick(8'h40, 1'b0, 1'b0);
    check(m, 8'h01);
    check(flag, 8'h01);
    check(oc, 8'h01);
    port_dir_in = 1'b1; // output state set up before the pin turns output
    #1 check(pin, 8'h01);
    check(pad, 8'h01);
    @(negedge mclk_in);
    fclr_in = 1'b1;
    @(negedge mclk_in);
    fclr_in = 1'b0;
    check(flag, 8'h00);
    tick(8'h40, 1'b0, 1'b0);
    check(oc, 8'h00);
    ack_in = 1'b1;
    @(negedge mclk_in);
    ack_in = 1'b0;
    check(flag, 8'h00);
    $display("test match done");
    // counter write swallows the match of the following tick only
    count_write_in = 1'b1; // a write onto the match value loses it
    @(negedge mclk_in);
    count_write_in = 1'b0;
    tick(8'h40, 1'b0, 1'b0);
    check(m, 8'h00);
    check(flag, 8'h00);
    tick(8'h40, 1'b0, 1'b0);
    check(m, 8'h01);
    check(oc, 8'h01);
    fclr_in = 1'b1;
    @(negedge mclk_in);
    fclr_in = 1'b0;
    $display("test block done");
    // forced matches in normal mode: clear, set, toggle twice, no flag, no pulse
    frc(toc_pkg::COM_CLEAR);
    check(m, 8'h00);
    check(oc, 8'h00);
    frc(toc_pkg::COM_SET);
    check(oc, 8'h01);
    frc(toc_pkg::COM_TOGGLE);
    check(oc, 8'h00);
    frc(toc_pkg::COM_TOGGLE);
    check(oc, 8'h01);
    check(flag, 8'h00);
    @(negedge mclk_in);
    check(oc, 8'h01);
    cfg.compare_output_mode = toc_pkg::COM_OFF;
    port_data_in = 1'b0;
    #1 check(pin, 8'h00);
    check(pad, 8'h00);
    $display("test force done");
    // fast pwm: mode change keeps the state, writes go to the buffer
    @(negedge mclk_in);
    cfg = '{toc_pkg::WGM_FAST_PWM, toc_pkg::COM_OFF};
    @(negedge mclk_in);
    check(oc, 8'h01);
    frc(toc_pkg::COM_CLEAR);
    check(oc, 8'h01);
    wr(8'h80);
    check(rdata, 8'h80);
    check(cval, 8'h40);
    tick(8'h10, 1'b1, 1'b0);
    check(cval, 8'h40);
    tick(8'h00, 1'b0, 1'b1);
    check(cval, 8'h80);
    tick(8'h80, 1'b0, 1'b0);
    check(m, 8'h01);
    check(oc, 8'h00);
    // phase correct pwm takes the buffer at top
    cfg.waveform_gen_mode = toc_pkg::WGM_PC_PWM;
    wr(8'h20);
    tick(8'h00, 1'b0, 1'b1);
    check(cval, 8'h80);
    check(oc, 8'h01);
    tick(8'hff, 1'b1, 1'b0);
    check(cval, 8'h20);
    $display("test pwm done");
    // clear-on-match mode: direct write, forced and real toggles
    cfg = '{toc_pkg::WGM_CLEAR_ON_MATCH, toc_pkg::COM_TOGGLE};
    wr(8'h30);
    check(cval, 8'h30);
    frc(toc_pkg::COM_TOGGLE);
    check(oc, 8'h00);
    tick(8'h30, 1'b0, 1'b0);
    check(m, 8'h01);
    check(oc, 8'h01);
    $display("test clear-on-match done");
    // a reset in mid-run clears the output state and the flag again
    rst_b_in = 1'b0;
    @(negedge mclk_in);
    rst_b_in = 1'b1;
    check(oc, 8'h00);
    check(flag, 8'h00);
    check(cval, 8'h00);
    $display("test reset again done");
    results();
  end
endmodule : toc_unit_tb
